// file: rtl/ioexp_pkg.sv
// Shared constants and state types for the serial-to-parallel expander link
package ioexp_pkg;
	// Byte and slot layout
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Fixed upper part of the 7-bit slave address
	localparam logic [3:0] ADDR_FIXED = 4'h7;
	localparam int ADDR_LSB_BITS = 3;
	// Direction bit values after the address
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	// Latch reset values
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] OUT_RESET = 8'h00;
	localparam logic [7:0] IN_RESET = 8'h00;
	// Timing: system clock and serial clock rate
	localparam int CLK_FREQ_KHZ = 50000;
	localparam int SCL_FREQ_KHZ = 100;
	localparam int SCL_QUARTER_CYC = CLK_FREQ_KHZ / (SCL_FREQ_KHZ * 4);
	localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);
	// Write data buffer
	localparam int FIFO_DEPTH = 8;
	// Expander end states
	typedef enum logic [8:0] {
		D_IDLE = 9'h001,
		D_ADDR = 9'h002,
		D_ADDR_ACK = 9'h004,
		D_DIR = 9'h008,
		D_WDATA = 9'h010,
		D_WACK = 9'h020,
		D_RDATA = 9'h040,
		D_RACK = 9'h080,
		D_IGNORE = 9'h100
	} dev_state_e;
	// Master end states
	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_START = 4'h2,
		M_BIT = 4'h4,
		M_STOP = 4'h8
	} mst_state_e;
endpackage

// file: rtl/i2c_pins_if.sv
// Open-drain two-wire bus joining the master end and the expander end
interface i2c_pins_if;
	logic scl_m_out;
	logic scl_m_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// Wired-AND with pull-up: any enabled driver pulls the line low
	assign scl = scl_m_oe ? scl_m_out : 1'b1;
	assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);
	modport master (output scl_m_out, output scl_m_oe, output sda_m_out, output sda_m_oe, input scl, input sda);
	modport expander (output sda_s_out, output sda_s_oe, input scl, input sda);
endinterface

// file: rtl/io_expander.sv
// Expander end: bus slave with direction, output and input latches
module io_expander (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Address straps
	input wire logic [2:0] addr_strap_i,
	// Parallel port pins
	input wire logic [7:0] port_pin_i,
	output logic [7:0] port_pin_o,
	output logic [7:0] port_pin_oe_o,
	// Serial bus
	i2c_pins_if.expander bus
);
	ioexp_pkg::dev_state_e state_q;
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic master_ack_q;
	logic sda_oe_q;
	logic [7:0] dir_q;
	logic [7:0] out_q;
	logic [7:0] in_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic addr_match;
	logic rx_state;

	// Previous line levels for edge and condition detection
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
		end
	end

	// Bus events
	assign scl_rise = bus.scl & ~scl_q;
	assign scl_fall = ~bus.scl & scl_q;
	assign start_cond = bus.scl & scl_q & sda_q & ~bus.sda;
	assign stop_cond = bus.scl & scl_q & ~sda_q & bus.sda;
	assign rx_state = (state_q == ioexp_pkg::D_ADDR) | (state_q == ioexp_pkg::D_DIR) |
		(state_q == ioexp_pkg::D_WDATA) | (state_q == ioexp_pkg::D_RDATA);
	assign byte_done = scl_fall & (bit_cnt_q == ioexp_pkg::BIT_CNT_FULL);
	assign addr_match = (rx_q[7:1] == {ioexp_pkg::ADDR_FIXED, addr_strap_i});

	// Bit counter and receive shifter, MSB arrives first
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_q <= 4'h0;
			rx_q <= 8'h00;
		end else if (start_cond || stop_cond) begin
			bit_cnt_q <= 4'h0;
		end else if (byte_done) begin
			bit_cnt_q <= 4'h0;
		end else if (scl_rise && rx_state) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			rx_q <= {rx_q[6:0], bus.sda};
		end
	end

	// Transaction sequencer and SDA driver
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ioexp_pkg::D_IDLE;
			rw_q <= ioexp_pkg::DIR_WRITE;
			master_ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			tx_q <= 8'h00;
		end else if (start_cond) begin
			state_q <= ioexp_pkg::D_ADDR;
			sda_oe_q <= 1'b0;
		end else if (stop_cond) begin
			state_q <= ioexp_pkg::D_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				ioexp_pkg::D_ADDR: begin
					if (byte_done) begin
						if (addr_match) begin
							state_q <= ioexp_pkg::D_ADDR_ACK;
							rw_q <= rx_q[0];
							sda_oe_q <= 1'b1;
						end else begin
							state_q <= ioexp_pkg::D_IGNORE;
						end
					end
				end
				ioexp_pkg::D_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_q == ioexp_pkg::DIR_READ) begin
							state_q <= ioexp_pkg::D_RDATA;
							sda_oe_q <= ~in_q[7];
							tx_q <= {in_q[6:0], 1'b0};
						end else begin
							state_q <= ioexp_pkg::D_DIR;
							sda_oe_q <= 1'b0;
						end
					end
				end
				ioexp_pkg::D_DIR, ioexp_pkg::D_WDATA: begin
					if (byte_done) begin
						state_q <= ioexp_pkg::D_WACK;
						sda_oe_q <= 1'b1;
					end
				end
				ioexp_pkg::D_WACK: begin
					if (scl_fall) begin
						state_q <= ioexp_pkg::D_WDATA;
						sda_oe_q <= 1'b0;
					end
				end
				ioexp_pkg::D_RDATA: begin
					if (byte_done) begin
						state_q <= ioexp_pkg::D_RACK;
						sda_oe_q <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end
				ioexp_pkg::D_RACK: begin
					if (scl_rise) begin
						master_ack_q <= ~bus.sda;
					end else if (scl_fall) begin
						if (master_ack_q) begin
							state_q <= ioexp_pkg::D_RDATA;
							sda_oe_q <= ~in_q[7];
							tx_q <= {in_q[6:0], 1'b0};
						end else begin
							state_q <= ioexp_pkg::D_IGNORE;
						end
					end
				end
				default: begin
					// Idle or ignoring: wait for a start, keep the line free
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Direction latch: first byte after address in write mode
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dir_q <= ioexp_pkg::DIR_RESET;
		end else if ((state_q == ioexp_pkg::D_DIR) && byte_done) begin
			dir_q <= rx_q;
		end
	end

	// Output latch: every later write byte
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_q <= ioexp_pkg::OUT_RESET;
		end else if ((state_q == ioexp_pkg::D_WDATA) && byte_done) begin
			out_q <= rx_q;
		end
	end

	// Input latch: pin levels at the eighth falling edge of a matching read address byte and of each read data byte
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_q <= ioexp_pkg::IN_RESET;
		end else if (byte_done && (((state_q == ioexp_pkg::D_ADDR) && addr_match && rx_q[0]) ||
			(state_q == ioexp_pkg::D_RDATA))) begin
			in_q <= port_pin_i;
		end
	end

	// Pin drivers follow the latches bit for bit
	assign port_pin_o = out_q;
	assign port_pin_oe_o = dir_q;
	assign bus.sda_s_out = 1'b0;
	assign bus.sda_s_oe = sda_oe_q;
endmodule // io_expander

// file: rtl/io_expander_master.sv
// Master end: write data buffer and bus transaction engine

// Synchronous FIFO with valid and ready on both sides
module xfer_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;

	assign out_valid_o = (count_q != '0);
	assign out_data_o = mem_q[rd_ptr_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	// Pointers, fill count and registered ready, so ready leaves straight from a flop
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
			end
			count_q <= count_d;
			in_ready_o <= (count_d != (AW+1)'(DEPTH));
		end
	end
endmodule // xfer_fifo

// Bus master: one transaction per request, write bytes taken from the FIFO
module io_expander_master (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Transaction request
	input wire logic xfer_start_i,
	input wire logic xfer_read_i,
	input wire logic [2:0] xfer_addr_i,
	input wire logic [7:0] xfer_len_i,
	output logic busy_o,
	output logic nack_o,
	// Write bytes: direction byte first, then output bytes
	input wire logic wr_valid_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_ready_o,
	// Read bytes
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	// Serial bus
	i2c_pins_if.master bus
);
	ioexp_pkg::mst_state_e state_q;
	logic [7:0] tick_q;
	logic [1:0] quarter_q;
	logic [3:0] slot_q;
	logic [7:0] rem_q;
	logic is_addr_q;
	logic rw_q;
	logic ack_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic f_valid;
	logic [7:0] f_data;
	logic tick;
	logic need_data;
	logic sending;
	logic stall;

	xfer_fifo #(.WIDTH(ioexp_pkg::BYTE_BITS), .DEPTH(ioexp_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.in_valid_i(wr_valid_i),
		.in_data_i(wr_data_i),
		.in_ready_o(wr_ready_o),
		.out_valid_o(f_valid),
		.out_data_o(f_data),
		.out_ready_i(tick && need_data)
	);

	assign sending = is_addr_q | (rw_q == ioexp_pkg::DIR_WRITE);
	assign need_data = (state_q == ioexp_pkg::M_BIT) && (quarter_q == 2'h0) && (slot_q == 4'h0) &&
		!is_addr_q && (rw_q == ioexp_pkg::DIR_WRITE);
	assign stall = need_data & ~f_valid;
	assign tick = (tick_q == ioexp_pkg::QUARTER_LAST) & ~stall;

	// Quarter-period timer; holds SCL low while write data is missing
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_q <= 8'h00;
		end else if (state_q == ioexp_pkg::M_IDLE || tick) begin
			tick_q <= 8'h00;
		end else if (!stall) begin
			tick_q <= tick_q + 8'h01;
		end
	end

	// Sequencer: start, nine-slot bytes, stop
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ioexp_pkg::M_IDLE;
			quarter_q <= 2'h0;
			slot_q <= 4'h0;
			rem_q <= 8'h00;
			is_addr_q <= 1'b0;
			rw_q <= ioexp_pkg::DIR_WRITE;
			ack_q <= 1'b0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_o <= 1'b0;
			nack_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else begin
			nack_o <= 1'b0;
			rd_valid_o <= 1'b0;
			if (state_q == ioexp_pkg::M_IDLE) begin
				if (xfer_start_i) begin
					state_q <= ioexp_pkg::M_START;
					quarter_q <= 2'h0;
					busy_o <= 1'b1;
					rw_q <= xfer_read_i;
					rem_q <= xfer_len_i;
					is_addr_q <= 1'b1;
					tx_q <= {ioexp_pkg::ADDR_FIXED, xfer_addr_i, xfer_read_i};
				end
			end else if (tick) begin
				quarter_q <= quarter_q + 2'h1;
				case (state_q)
					ioexp_pkg::M_START: begin
						// SDA falls while SCL is high, then SCL falls
						if (quarter_q == 2'h1) begin
							sda_oe_q <= 1'b1;
						end else if (quarter_q == 2'h2) begin
							scl_oe_q <= 1'b1;
							state_q <= ioexp_pkg::M_BIT;
							quarter_q <= 2'h0;
							slot_q <= 4'h0;
						end
					end
					ioexp_pkg::M_BIT: begin
						case (quarter_q)
							2'h0: begin
								if (slot_q == ioexp_pkg::ACK_SLOT) begin
									sda_oe_q <= !sending && (rem_q != 8'h01);
								end else if (!sending) begin
									sda_oe_q <= 1'b0;
								end else if (need_data) begin
									sda_oe_q <= ~f_data[7];
									tx_q <= {f_data[6:0], 1'b0};
								end else begin
									sda_oe_q <= ~tx_q[7];
									tx_q <= {tx_q[6:0], 1'b0};
								end
							end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								if (slot_q == ioexp_pkg::ACK_SLOT) begin
									ack_q <= ~bus.sda;
								end else begin
									rx_q <= {rx_q[6:0], bus.sda};
								end
							end
							default: begin
								scl_oe_q <= 1'b1;
								slot_q <= slot_q + 4'h1;
								if (slot_q == ioexp_pkg::ACK_SLOT) begin
									slot_q <= 4'h0;
									is_addr_q <= 1'b0;
									if (!is_addr_q) begin
										rem_q <= rem_q - 8'h01;
									end
									if (!sending && !is_addr_q) begin
										rd_valid_o <= 1'b1;
										rd_data_o <= rx_q;
									end
									if (sending && !ack_q) begin
										nack_o <= 1'b1;
										state_q <= ioexp_pkg::M_STOP;
									end else if (is_addr_q ? (rem_q == 8'h00) : (rem_q == 8'h01)) begin
										state_q <= ioexp_pkg::M_STOP;
									end
								end
							end
						endcase
					end
					default: begin
						// Stop: SDA low under low SCL, SCL high, then SDA rises
						if (quarter_q == 2'h0) begin
							sda_oe_q <= 1'b1;
						end else if (quarter_q == 2'h1) begin
							scl_oe_q <= 1'b0;
						end else if (quarter_q == 2'h2) begin
							sda_oe_q <= 1'b0;
						end else begin
							state_q <= ioexp_pkg::M_IDLE;
							busy_o <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// Open-drain drivers only ever pull low
	assign bus.scl_m_out = 1'b0;
	assign bus.scl_m_oe = scl_oe_q;
	assign bus.sda_m_out = 1'b0;
	assign bus.sda_m_oe = sda_oe_q;
endmodule // io_expander_master

// file: test/ioexp_asserts.sv
// Checker for the two-wire link between the master end and the expander end
module ioexp_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Bus lines and drivers
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_m_oe_i,
	input wire logic sda_m_oe_i,
	input wire logic sda_s_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Bus events seen on the wires
	sequence start_s;
		$fell(sda_i) && scl_i;
	endsequence
	sequence stop_s;
		$rose(sda_i) && scl_i;
	endsequence
	sequence scl_fell_s;
		$past(scl_i, 2) && !$past(scl_i);
	endsequence
	// All drivers quiet on the first edge after reset
	rst_quiet_a: assert property (!$past(resetn_i) |-> !sda_s_oe_i && !sda_m_oe_i && !scl_m_oe_i)
		else $error("bus driven right after reset");
	// Expander moves SDA only one clock after an SCL fall
	slave_edge_a: assert property ($changed(sda_s_oe_i) |-> scl_fell_s)
		else $error("expander SDA change not tied to SCL fall");
	slave_hold_a: assert property ($changed(sda_s_oe_i) |=> $stable(sda_s_oe_i)[*8])
		else $error("expander SDA glitch");
	// Start and stop framing
	start_hold_a: assert property (start_s |-> scl_i[*8])
		else $error("SCL fell too soon after start");
	start_clock_a: assert property (start_s |-> ##[1:300] !scl_i)
		else $error("no clock after start");
	stop_idle_a: assert property (stop_s |=> (scl_i && sda_i)[*8])
		else $error("bus not idle after stop");
	stop_free_a: assert property (stop_s |-> !scl_m_oe_i && !sda_s_oe_i)
		else $error("line still driven at stop");
	// Clock phases long enough to carry one bit
	scl_high_a: assert property ($rose(scl_i) |-> scl_i[*8])
		else $error("SCL high phase too short");
	scl_low_a: assert property ($fell(scl_i) |-> !scl_i[*8])
		else $error("SCL low phase too short");
endmodule // ioexp_asserts

// file: test/tb_top.sv
// Self-checking bench: master end talks to the expander end over the shared bus
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, resetn_i, xfer_start, xfer_read, wr_valid, busy, nack, wr_ready, rd_valid;
	logic [2:0] strap, xfer_addr;
	logic [7:0] xfer_len, wr_data, rd_data, ext_pins, pin_o, pin_oe, pins, dir_b, data_b;
	int seed = 97296;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int nacks = 0;
	int rd_q[$];
	i2c_pins_if i_i2c_pins_if ();
	// Pin level on the board: driven bits win over the outside
	assign pins = (pin_oe & pin_o) | (~pin_oe & ext_pins);
	io_expander i_io_expander (.clk_i(clk_i), .resetn_i(resetn_i), .addr_strap_i(strap), .port_pin_i(pins),
		.port_pin_o(pin_o), .port_pin_oe_o(pin_oe), .bus(i_i2c_pins_if));
	io_expander_master i_io_expander_master (.clk_i(clk_i), .resetn_i(resetn_i), .xfer_start_i(xfer_start),
		.xfer_read_i(xfer_read), .xfer_addr_i(xfer_addr), .xfer_len_i(xfer_len), .busy_o(busy), .nack_o(nack),
		.wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
		.rd_data_o(rd_data), .bus(i_i2c_pins_if));
	ioexp_asserts i_ioexp_asserts (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(i_i2c_pins_if.scl),
		.sda_i(i_i2c_pins_if.sda), .scl_m_oe_i(i_i2c_pins_if.scl_m_oe), .sda_m_oe_i(i_i2c_pins_if.sda_m_oe),
		.sda_s_oe_i(i_i2c_pins_if.sda_s_oe));
	// Compare and count
	task automatic check(input string what, input int exp, input logic [7:0] got);
		n_compared++;
		if ({1'b0, got} !== 9'(exp)) begin
			mismatches++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Hand one word to the buffer, waiting while it is full
	task automatic push(input logic [7:0] b);
		while (wr_ready !== 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		wr_valid = 1'b1;
		wr_data = b;
		@(posedge clk_i);
		#1;
		wr_valid = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	// One transaction, waiting until the master is idle again
	task automatic run(input logic rd, input logic [2:0] adr, input logic [7:0] len);
		xfer_read = rd;
		xfer_addr = adr;
		xfer_len = len;
		xfer_start = 1'b1;
		@(posedge clk_i);
		#1;
		xfer_start = 0;
		while (busy !== 1'b0) begin
			@(posedge clk_i);
			#1;
		end
	endtask
	// Read with model expectations from latches and outside levels
	task automatic rd(input logic [2:0] adr, input int n);
		if (adr == strap) begin
			repeat (n) rd_q.push_back(int'((dir_b & data_b) | (~dir_b & ext_pins)));
		end
		run(1'b1, adr, 8'(n));
		check("bytes left", 0, 8'(rd_q.size()));
		check("direction kept", dir_b, pin_oe);
	endtask
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Cycle limit and monitors of nack and read bytes
	always @(posedge clk_i) begin
		cycles++;
		if (nack === 1'b1) begin
			nacks++;
		end
		if (rd_valid === 1'b1) begin
			check("read byte", rd_q.size() > 0 ? rd_q.pop_front() : -1, rd_data);
		end
		if (cycles == 100000) begin
			mismatches++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		resetn_i = 1'b0;
		{xfer_start, xfer_read, wr_valid} = 3'h0;
		xfer_addr = 3'h0;
		xfer_len = 8'h00;
		wr_data = 8'h00;
		strap = 3'($random(seed));
		ext_pins = 8'($random(seed));
		dir_b = 8'($random(seed));
		repeat (8) @(posedge clk_i);
		#1;
		resetn_i = 1'b1;
		check("direction after reset", 0, pin_oe);
		check("output after reset", 0, pin_o);
		// Fill the buffer: direction byte then seven output bytes
		push(dir_b);
		repeat (7) begin
			data_b = 8'($random(seed));
			push(data_b);
		end
		check("ready when full", 0, 8'(wr_ready));
		run(1'b0, strap, 8'h08);
		check("direction latch", dir_b, pin_oe);
		check("output latch", data_b, pin_o);
		check("ready when empty", 1, 8'(wr_ready));
		// Reads with fresh outside levels, then one to a foreign address
		repeat (2) begin
			ext_pins = 8'($random(seed));
			rd(strap, 2);
		end
		check("nacks on own address", 0, 8'(nacks));
		rd(strap ^ (3'($random(seed)) | 3'h1), 1);
		check("nacks on foreign address", 1, 8'(nacks));
		// Reset in mid-run returns every pin to input; a read then sees only outside levels
		resetn_i = 1'b0;
		@(posedge clk_i);
		#1;
		check("direction after second reset", 0, pin_oe);
		check("output after second reset", 0, pin_o);
		resetn_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check("busy after second reset", 0, 8'(busy));
		check("direction after release", 0, pin_oe);
		dir_b = 8'h00;
		data_b = 8'h00;
		rd(strap, 1);
		give_verdict();
	end
endmodule // tb_top
